// File: hw/event_status_regs.v
// Event status and checksum result registers behind the serial link.
`timescale 1ns/1ps
module event_status_regs
(
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // Serial link pins
   input  wire        csN,
   input  wire        sclk,
   input  wire        sdi,
   // Monitor condition levels and events
   input  wire        supplyLowLevel,
   input  wire        supplyHighLevel,
   input  wire        thermalWarnLevel,
   input  wire        thermalShutdownLevel,
   input  wire [23:0] inputCross,
   input  wire        pollFirstDone,
   input  wire        softReset,
   input  wire        checksumDone,
   input  wire [15:0] checksumValue,
   // Results
   output reg  [23:0] readData,
   output reg         readValid,
   output reg         parityStatusFlag,
   output reg         lengthStatusFlag,
   output reg         resetStatusFlag,
   output reg         intN
);
`include "event_regs_consts.vh"

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   reg  [1:0] csSync_q;
   reg  [2:0] sclkSync_q;
   reg  [1:0] sdiSync_q;
   reg  [3:0] lvlSync0_q;
   reg  [3:0] lvlSync1_q;
   reg  [3:0] lvlPrev_q;

   always @(posedge clk)
   begin
      if (reset)
      begin
         csSync_q   <= 2'h3;
         sclkSync_q <= 3'h0;
         sdiSync_q  <= 2'h0;
         lvlSync0_q <= 4'h0;
         lvlSync1_q <= 4'h0;
         lvlPrev_q  <= 4'h0;
      end
      else
      begin
         csSync_q   <= {csSync_q[0], csN};
         sclkSync_q <= {sclkSync_q[1:0], sclk};
         sdiSync_q  <= {sdiSync_q[0], sdi};
         lvlSync0_q <= {supplyLowLevel, supplyHighLevel, thermalWarnLevel,
                        thermalShutdownLevel};
         lvlSync1_q <= lvlSync0_q;
         lvlPrev_q  <= lvlSync1_q;
      end
   end

   wire       csLowSync = ~csSync_q[1];
   wire       sclkRise  = sclkSync_q[1] & ~sclkSync_q[2];
   // Both edges count, since the flag marks a condition starting or ending.
   wire [3:0] lvlToggle = lvlSync1_q ^ lvlPrev_q;

   // ---------------------------------------------------------------
   // Frame receiver
   // ---------------------------------------------------------------
   reg         syncSoftReset_q;
   // Soft reset is treated like the hardware reset but one cycle late.
   wire        anyReset = reset | syncSoftReset_q;
   wire        frameGood;
   wire        parityBad;
   wire        lengthBad;
   wire [31:0] frameWord;

   frame_receiver u_rx
   (
      .clk       (clk),
      .reset     (anyReset),
      .csLowSync (csLowSync),
      .sclkRise  (sclkRise),
      .sdiBit    (sdiSync_q[1]),
      .frameDone (),
      .frameGood (frameGood),
      .parityBad (parityBad),
      .lengthBad (lengthBad),
      .frameWord (frameWord)
   );

   // Frame layout: bit 31 command, bits 30:25 address, bit 0 parity.
   wire       readCmd  = frameGood & (frameWord[31] == `CMD_READ);
   wire [5:0] readAddr = frameWord[30:25];
   wire       readEvt  = readCmd & (readAddr == `ADDR_EVENT_STATUS);

   // ---------------------------------------------------------------
   // Event status register
   // ---------------------------------------------------------------
   reg  [23:0] eventStatus_q;
   reg  [23:0] eventSet;
   reg  [23:0] eventStatus_d;
   reg  [15:0] checksum_q;

   always @*
   begin
      eventSet = 24'h000000;
      eventSet[`BIT_SUPPLY_LOW]       = lvlToggle[3];
      eventSet[`BIT_SUPPLY_HIGH]      = lvlToggle[2];
      eventSet[`BIT_THERMAL_WARN]     = lvlToggle[1];
      eventSet[`BIT_THERMAL_SHUTDOWN] = lvlToggle[0];
      eventSet[`BIT_INPUT_CHANGE]     = (|inputCross) | pollFirstDone;
      eventSet[`BIT_PARITY_ERROR]     = parityBad;
      eventSet[`BIT_LENGTH_ERROR]     = lengthBad;
      eventSet[`BIT_CHECKSUM_DONE]    = checksumDone;
      // Set wins over the clearing read.
      if (readEvt)
         eventStatus_d = eventSet;
      else
         eventStatus_d = eventStatus_q | eventSet;
   end


   always @(posedge clk)
   begin
      if (reset)
         syncSoftReset_q <= 1'b0;
      else
         syncSoftReset_q <= softReset & ~syncSoftReset_q;
   end

   always @(posedge clk)
   begin
      if (anyReset)
      begin
         eventStatus_q    <= `RESET_EVENT_STATUS;
         checksum_q       <= `RESET_CHECKSUM;
         readData         <= 24'h000000;
         readValid        <= 1'b0;
         parityStatusFlag <= 1'b0;
         lengthStatusFlag <= 1'b0;
         resetStatusFlag  <= 1'b1;
         intN             <= 1'b0;
      end
      else
      begin
         eventStatus_q <= eventStatus_d;
         if (checksumDone)
            checksum_q <= checksumValue;
         readValid <= readCmd;
         if (readCmd)
         begin
            case (readAddr)
               `ADDR_EVENT_STATUS:    readData <= eventStatus_q;
               `ADDR_CHECKSUM_RESULT: readData <= {8'h00, checksum_q};
               default:               readData <= 24'h000000;
            endcase
         end
         parityStatusFlag <= eventStatus_q[`BIT_PARITY_ERROR];
         lengthStatusFlag <= eventStatus_q[`BIT_LENGTH_ERROR];
         resetStatusFlag  <= eventStatus_q[`BIT_RESET_SEEN];
         // The read is decoded as soon as its frame ends, so the pin lets go
         // at the chip select rise of that same frame, plus the pin lag.
         if (|eventSet)
            intN <= 1'b0;
         else if (readEvt)
            intN <= 1'b1;
         else if (eventStatus_q != 24'h000000)
            intN <= 1'b0;
      end
   end
endmodule // event_status_regs

// File: hw/event_regs_consts.vh
// Constants for the event status and checksum result register bank.
`ifndef EVENT_REGS_CONSTS_VH
`define EVENT_REGS_CONSTS_VH
`define ADDR_EVENT_STATUS     6'h02
`define ADDR_CHECKSUM_RESULT  6'h03
`define RESET_EVENT_STATUS    24'h000001
`define RESET_CHECKSUM        16'hffff
`define BIT_RESET_SEEN        0
`define BIT_LENGTH_ERROR      1
`define BIT_PARITY_ERROR      2
`define BIT_INPUT_CHANGE      3
`define BIT_THERMAL_SHUTDOWN  4
`define BIT_THERMAL_WARN      5
`define BIT_SUPPLY_HIGH       6
`define BIT_SUPPLY_LOW        7
`define BIT_CHECKSUM_DONE     8
`define FRAME_BITS            6'd32
`define CMD_READ              1'b0
`endif

// File: hw/frame_receiver.v
// Serial frame receiver: bit count, odd parity check and frame decode.
`timescale 1ns/1ps
module frame_receiver
(
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // Synchronised link pins
   input  wire        csLowSync,
   input  wire        sclkRise,
   input  wire        sdiBit,
   // Frame results
   output reg         frameDone,
   output reg         frameGood,
   output reg         parityBad,
   output reg         lengthBad,
   output reg  [31:0] frameWord
);
`include "event_regs_consts.vh"

   reg  [5:0]  bitCount_q;
   reg  [31:0] shift_q;
   reg         csLowPrev_q;
   reg         overflow_q;
   wire        frameEnd;
   wire        oddOnes;

   assign frameEnd = csLowPrev_q & ~csLowSync;
   assign oddOnes  = ^shift_q;

   always @(posedge clk)
   begin
      if (reset)
      begin
         bitCount_q  <= 6'h00;
         shift_q     <= 32'h00000000;
         csLowPrev_q <= 1'b0;
         overflow_q  <= 1'b0;
         frameDone   <= 1'b0;
         frameGood   <= 1'b0;
         parityBad   <= 1'b0;
         lengthBad   <= 1'b0;
         frameWord   <= 32'h00000000;
      end
      else
      begin
         csLowPrev_q <= csLowSync;
         frameDone   <= 1'b0;
         frameGood   <= 1'b0;
         parityBad   <= 1'b0;
         lengthBad   <= 1'b0;
         if (csLowSync & ~csLowPrev_q)
         begin
            bitCount_q <= 6'h00;
            overflow_q <= 1'b0;
         end
         else if (csLowSync & sclkRise)
         begin
            shift_q <= {shift_q[30:0], sdiBit};
            if (bitCount_q == `FRAME_BITS)
               overflow_q <= 1'b1;
            else
               bitCount_q <= bitCount_q + 6'd1;
         end
         // A frame with no clock pulses is silently ignored.
         if (frameEnd && bitCount_q != 6'h00)
         begin
            frameDone <= 1'b1;
            if (overflow_q || bitCount_q != `FRAME_BITS)
               lengthBad <= 1'b1;
            else if (!oddOnes)
               parityBad <= 1'b1;
            else
            begin
               frameGood <= 1'b1;
               frameWord <= shift_q;
            end
         end
      end
   end
endmodule // frame_receiver

// File: sim/event_status_regs_properties.sv
// Concurrent checks on the ports of the event status register bank.
`timescale 1ns/1ps
module event_status_regs_checker
(
   // Clock, reset and watched ports
   input wire        clk,
   input wire        reset,
   input wire        csN,
   input wire        supplyLowLevel,
   input wire [23:0] inputCross,
   input wire        checksumDone,
   input wire [23:0] readData,
   input wire        readValid,
   input wire        parityStatusFlag,
   input wire        lengthStatusFlag,
   input wire        resetStatusFlag,
   input wire        intN
);
   default clocking cb @(posedge clk); endclocking
   property p_rstFlag; reset ##1 reset |=> resetStatusFlag && !intN; endproperty
   a_rstFlag: assert property (p_rstFlag) else $error("reset flag wrong");
   property p_rstErr; reset ##1 reset |=> !parityStatusFlag && !lengthStatusFlag; endproperty
   a_rstErr: assert property (p_rstErr) else $error("error flags kept");
   property p_rstRead; reset |=> readData == 24'h000000 && !readValid; endproperty
   a_rstRead: assert property (p_rstRead) else $error("read port kept");
   property p_lowEvent; disable iff (reset) $rose(supplyLowLevel) |-> ##[1:8] !intN; endproperty
   a_lowEvent: assert property (p_lowEvent) else $error("no supply event");
   property p_crossEvent; disable iff (reset) |inputCross |-> ##[1:6] !intN; endproperty
   a_crossEvent: assert property (p_crossEvent) else $error("no cross event");
   property p_doneEvent; disable iff (reset) checksumDone |-> ##[1:6] !intN; endproperty
   a_doneEvent: assert property (p_doneEvent) else $error("no done event");
   property p_reserved; disable iff (reset) readValid |-> readData[23:16] == 8'h00; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");
   property p_release; disable iff (reset) $rose(intN) |-> csN && $past(csN, 2); endproperty
   a_release: assert property (p_release) else $error("early release");
endmodule // event_status_regs_checker

bind event_status_regs event_status_regs_checker chk (.clk, .reset, .csN, .supplyLowLevel,
   .inputCross, .checksumDone, .readData, .readValid, .parityStatusFlag,
   .lengthStatusFlag, .resetStatusFlag, .intN);

// File: sim/host_link_model.sv
// Host controller model that clocks frames into the register bank.
`timescale 1ns/1ps
module host_link_model
(
   // Link pins
   output reg csN,
   output reg sclk,
   output reg sdi
);
   initial {csN, sclk, sdi} = 3'b100;
   // The clock stands still outside frames; a released data line turns over.
   task frame(input [31:0] w, input integer n);
      integer i;
      #80 csN = 1'b0;
      #40;
      for (i = 0; i < n; i = i + 1)
      begin
         sdi = (i < 32) ? w[31 - i] : 1'b0;
         #16 sclk = 1'b1;
         #16 sclk = 1'b0;
      end
      #16 csN = 1'b1;
      sdi = ~sdi;
   endtask
endmodule // host_link_model

// File: sim/event_status_regs_bench.sv
// Self-checking bench for the event status register bank.
`timescale 1ns/1ps
`include "event_regs_consts.vh"
module event_status_regs_bench;
   reg         clk, reset, supplyLowLevel, supplyHighLevel, thermalWarnLevel;
   reg         thermalShutdownLevel, pollFirstDone, checksumDone, softReset;
   reg  [23:0] inputCross;
   reg  [15:0] checksumValue;
   wire        csN, sclk, sdi, readValid, parityStatusFlag, lengthStatusFlag;
   wire        resetStatusFlag, intN;
   wire [23:0] readData;
   integer     errors, n_tests, i;
   host_link_model host (.csN, .sclk, .sdi);
   event_status_regs uut (.clk, .reset, .csN, .sclk, .sdi, .supplyLowLevel, .supplyHighLevel,
      .thermalWarnLevel, .thermalShutdownLevel, .inputCross, .pollFirstDone, .softReset,
      .checksumDone, .checksumValue, .readData, .readValid, .parityStatusFlag,
      .lengthStatusFlag, .resetStatusFlag, .intN);
   always #2 clk = ~clk;
   function [31:0] mk(input [5:0] a);
      mk = {`CMD_READ, a, 25'h0};
      mk[0] = ~^mk[31:1];
   endfunction
   task cmp(input [79:0] s, input [23:0] e, input [23:0] g);
      n_tests = n_tests + 1;
      if (g !== e)
      begin
         errors = errors + 1;
         $display("MISMATCH %0s expected %h seen %h", s, e, g);
      end
   endtask
   task cmp1(input [79:0] s, input e, input g);
      cmp(s, {23'h0, e}, {23'h0, g});
   endtask
   task rd(input [5:0] a, input [23:0] e);
      host.frame(mk(a), 32);
      for (i = 0; i < 40 && readValid !== 1'b1; i = i + 1)
         @(negedge clk);
      cmp1("readValid", 1'b1, readValid);
      cmp("readData", e, readData);
      @(negedge clk);
   endtask
   // Levels are set together so that every edge lands in one sampling window.
   task ev(input [3:0] lv, input [23:0] x, input [2:0] p);
      {supplyLowLevel, supplyHighLevel, thermalWarnLevel, thermalShutdownLevel} = lv;
      inputCross = x;
      {pollFirstDone, checksumDone, softReset} = p;
      @(negedge clk);
      inputCross = 24'h0;
      {pollFirstDone, checksumDone, softReset} = 3'b000;
      repeat (12) @(negedge clk);
   endtask
   task fr(input [31:0] w, input integer n);
      host.frame(w, n);
      repeat (12) @(negedge clk);
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      errors = errors + 1;
      conclude;
   end
   initial
   begin
      {clk, reset, supplyLowLevel, supplyHighLevel, thermalWarnLevel} = 5'b01000;
      {thermalShutdownLevel, pollFirstDone, checksumDone, softReset} = 4'h0;
      inputCross = 24'h0;
      checksumValue = 16'ha5c3;
      errors = 0;
      n_tests = 0;
      repeat (10) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      cmp1("rstFlag", 1'b1, resetStatusFlag);
      cmp1("intN", 1'b0, intN);
      rd(`ADDR_EVENT_STATUS, 24'h000001);
      cmp1("intN", 1'b1, intN);
      rd(`ADDR_EVENT_STATUS, 24'h000000);
      rd(`ADDR_CHECKSUM_RESULT, 24'h00ffff);
      cmp1("intN", 1'b1, intN);
      $display("test reset done");
      ev(4'h8, 24'h800000, 3'b010);
      rd(`ADDR_EVENT_STATUS, 24'h000188);
      rd(`ADDR_CHECKSUM_RESULT, 24'h00a5c3);
      ev(4'h7, 24'h0, 3'b100);
      rd(`ADDR_EVENT_STATUS, 24'h0000f8);
      ev(4'h0, 24'h000001, 3'b000);
      rd(`ADDR_EVENT_STATUS, 24'h000078);
      $display("test events done");
      fr(mk(`ADDR_EVENT_STATUS) ^ 32'h1, 32);
      cmp1("parFlag", 1'b1, parityStatusFlag);
      rd(`ADDR_EVENT_STATUS, 24'h000004);
      fr(mk(`ADDR_EVENT_STATUS), 31);
      cmp1("lenFlag", 1'b1, lengthStatusFlag);
      rd(`ADDR_EVENT_STATUS, 24'h000002);
      fr(mk(`ADDR_EVENT_STATUS), 33);
      rd(`ADDR_EVENT_STATUS, 24'h000002);
      fr(32'h0, 0);
      rd(`ADDR_EVENT_STATUS, 24'h000000);
      $display("test errors done");
      ev(4'h0, 24'h0, 3'b001);
      rd(6'h01, 24'h000000);
      rd(`ADDR_EVENT_STATUS, 24'h000001);
      rd(`ADDR_CHECKSUM_RESULT, 24'h00ffff);
      $display("test soft reset done");
      conclude;
   end
endmodule // event_status_regs_bench
